// ===== pkg/eprom_ctl_pkg.sv
// shared types, pin layout and timing counts for the eprom programming host
// assumes a single 10 MHz clock and one eprom (or a parallel bank) on the pins
package eprom_ctl_pkg;

  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;

  // clock and device timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int ACCESS_NS     = 450;
  localparam int ACCESS_CYC    = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELEASE_NS    = 100;
  localparam int RELEASE_RAW   = (RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELEASE_CYC   = (RELEASE_RAW < 1) ? 1 : RELEASE_RAW;
  localparam int PULSE_MS      = 50;
  localparam int PULSE_CYC     = PULSE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PULSE_MAX_MS  = 55;
  localparam int PULSE_MAX_CYC = PULSE_MAX_MS * 1000000 / CLK_PERIOD_NS;
  // pin edge to settled synchroniser output
  localparam int SYNC_LAT      = 4;
  localparam int SETUP_CYC     = 2;

  typedef enum logic
  {
    OP_READ    = 1'b0,
    OP_PROGRAM = 1'b1
  } op_t;

  typedef struct packed
  {
    op_t               op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cmd_t;

  typedef struct packed
  {
    logic [DATA_W-1:0] data;
    logic              match;
  } rsp_t;

  typedef struct packed
  {
    logic [ADDR_W-1:0] addr;
    logic              csStrobe;
    logic              outGate_n;
    logic              vppHigh;
    logic [DATA_W-1:0] dataOut;
    logic              dataOe;
  } pins_t;

  // standby: strobe high, gate high, supply at read level, bus released
  localparam pins_t PINS_IDLE = '{addr: 11'h000, csStrobe: 1'b1, outGate_n: 1'b1,
                                  vppHigh: 1'b0, dataOut: 8'h00, dataOe: 1'b0};

endpackage

// ===== hdl/pin_sync.sv
// three-stage synchroniser with agreement filter for pin inputs
// assumes d is asynchronous to ref_clk
`timescale 1ns/100ps
`default_nettype none
module pin_sync
#(
  parameter int W = 8
)
(
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] s1Q;
  logic [W-1:0] s2Q;
  logic [W-1:0] s3Q;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      s1Q <= '0;
      s2Q <= '0;
      s3Q <= '0;
      q   <= '0;
    end
    else
    begin
      s1Q <= d;
      s2Q <= s1Q;
      s3Q <= s2Q;
      for (int i = 0; i < W; i++)
      begin
        if (s2Q[i] == s3Q[i])
        begin
          q[i] <= s3Q[i];
        end
      end
    end
  end

endmodule // pin_sync
`default_nettype wire

// ===== hdl/eprom_prog_host.sv
// host sequencer that reads and programs a uv eprom through its pins
// assumes the eprom data bus is resolved outside from dataOe; one clock
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - supply high, gate high: host drives data
// - one 50 ms high pulse, never over 55
// - never program with a static high strobe
// - one pulse per programmed address
// - verify with supply high, strobe and gate low
// - supply high only in program, verify, inhibit
// - shared strobe programs paralleled devices alike
// - separate strobes give different data in parallel
// - gate follows read strobe; avoid bus contention
module eprom_prog_host
#(
  parameter int PULSE_CYC     = eprom_ctl_pkg::PULSE_CYC,
  parameter int PULSE_MAX_CYC = eprom_ctl_pkg::PULSE_MAX_CYC,
  parameter int SETUP_CYC     = eprom_ctl_pkg::SETUP_CYC
)
(
  input  wire logic                               ref_clk,
  input  wire logic                               rst_n,
  input  wire logic                               cmdValid,
  input  wire eprom_ctl_pkg::cmd_t                cmdIn,
  output var  logic                               cmdReady,
  output var  logic                               rspValid,
  output var  eprom_ctl_pkg::rsp_t                rspOut,
  output var  eprom_ctl_pkg::pins_t               pinsOut,
  input  wire logic [eprom_ctl_pkg::DATA_W-1:0]   dataIn
);
  import eprom_ctl_pkg::*;

  localparam int CNT_W = $clog2(PULSE_MAX_CYC + 2);

  typedef enum logic [2:0]
  {
    IDLE      = 3'h0,
    PG_SETUP  = 3'h1,
    PG_PULSE  = 3'h3,
    PG_HOLD   = 3'h2,
    PG_VERIFY = 3'h6,
    FINISH    = 3'h4,
    RD_ACC    = 3'h5
  } state_t;

  state_t            stateQ;
  state_t            stateD;
  logic [CNT_W-1:0]  waitQ;
  logic [CNT_W-1:0]  waitD;
  cmd_t              cmdQ;
  pins_t             pinsD;
  logic [DATA_W-1:0] dataSync;
  logic [CNT_W:0]    hiCntQ;

  wire logic waitDone  = (waitQ == '0);
  wire logic accept    = cmdValid && cmdReady;
  wire cmd_t cmdCur    = accept ? cmdIn : cmdQ;
  wire logic sampleNow = waitDone && ((stateQ == RD_ACC) || (stateQ == PG_VERIFY));
  // programming only clears bits, so the stored word must equal the written one
  wire logic wordMatch = (stateQ == RD_ACC) || (dataSync == cmdQ.data);

  pin_sync #(.W(DATA_W)) dataSyncU
  (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .d       (dataIn),
    .q       (dataSync)
  );

  // cycles a state lasts, minus one
  function automatic logic [CNT_W-1:0] loadFor(input state_t s);
    logic [CNT_W-1:0] n;
    n = '0;
    unique case (s)
      RD_ACC:    n = CNT_W'(ACCESS_CYC + SYNC_LAT - 1);
      PG_SETUP:  n = CNT_W'(SETUP_CYC - 1);
      PG_PULSE:  n = CNT_W'(PULSE_CYC - 1);
      PG_HOLD:   n = CNT_W'(SETUP_CYC - 1);
      PG_VERIFY: n = CNT_W'(ACCESS_CYC + SYNC_LAT - 1);
      FINISH:    n = CNT_W'(RELEASE_CYC - 1);
      IDLE:      n = '0;
    endcase
    return n;
  endfunction

  always_comb
  begin
    stateD = stateQ;
    unique case (stateQ)
      IDLE:
      begin
        if (accept)
        begin
          stateD = (cmdIn.op == OP_PROGRAM) ? PG_SETUP : RD_ACC;
        end
      end
      RD_ACC:    stateD = waitDone ? FINISH : RD_ACC;
      PG_SETUP:  stateD = waitDone ? PG_PULSE : PG_SETUP;
      PG_PULSE:  stateD = waitDone ? PG_HOLD : PG_PULSE;
      PG_HOLD:   stateD = waitDone ? PG_VERIFY : PG_HOLD;
      PG_VERIFY: stateD = waitDone ? FINISH : PG_VERIFY;
      FINISH:    stateD = waitDone ? IDLE : FINISH;
      default:   stateD = IDLE;
    endcase
  end

  assign waitD = (stateD != stateQ) ? loadFor(stateD) :
                 (waitDone ? waitQ : waitQ - CNT_W'(1));

  wire logic progState = (stateD == PG_SETUP) || (stateD == PG_PULSE) ||
                         (stateD == PG_HOLD) || (stateD == PG_VERIFY);

  // pin levels follow the state being entered, so pins change with the state
  always_comb
  begin
    pinsD           = PINS_IDLE;
    pinsD.addr      = cmdCur.addr;
    pinsD.dataOut   = cmdCur.data;
    pinsD.vppHigh   = progState;
    pinsD.csStrobe  = (stateD == IDLE) || (stateD == PG_PULSE);
    pinsD.outGate_n = !((stateD == RD_ACC) || (stateD == PG_VERIFY));
    pinsD.dataOe    = (stateD == PG_SETUP) || (stateD == PG_PULSE) ||
                      ((stateD == PG_HOLD) && (waitD != '0));
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      stateQ   <= IDLE;
      waitQ    <= '0;
      cmdQ     <= '{op: OP_READ, addr: 11'h000, data: 8'h00};
      pinsOut  <= PINS_IDLE;
      cmdReady <= 1'b0;
      rspValid <= 1'b0;
      rspOut   <= '{data: 8'h00, match: 1'b0};
    end
    else
    begin
      stateQ   <= stateD;
      waitQ    <= waitD;
      cmdQ     <= cmdCur;
      pinsOut  <= pinsD;
      cmdReady <= (stateD == IDLE);
      rspValid <= sampleNow;
      if (sampleNow)
      begin
        rspOut <= '{data: dataSync, match: wordMatch};
      end
    end
  end

  // helper: length of the current programming pulse
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      hiCntQ <= '0;
    end
    else
    begin
      hiCntQ <= (pinsOut.csStrobe && pinsOut.vppHigh) ? hiCntQ + (CNT_W+1)'(1) : '0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_pulse_max_width: assert property (hiCntQ <= PULSE_MAX_CYC)
    else $error("program pulse exceeds maximum width");
  a_pulse_exact_width: assert property
    ($fell(pinsOut.csStrobe) && $past(pinsOut.vppHigh) |-> hiCntQ == PULSE_CYC)
    else $error("program pulse width differs from nominal");
  a_no_static_high: assert property
    (pinsOut.csStrobe && pinsOut.vppHigh |-> stateQ == PG_PULSE)
    else $error("strobe high under programming supply outside pulse");
  a_one_pulse_cmd: assert property
    ($rose(pinsOut.csStrobe) && pinsOut.vppHigh |-> $past(stateQ) == PG_SETUP)
    else $error("program pulse not preceded by setup");
  a_prog_drive_gate: assert property
    (pinsOut.csStrobe && pinsOut.vppHigh |-> pinsOut.outGate_n && pinsOut.dataOe)
    else $error("pulse without gate high and data driven");
  a_no_bus_fight: assert property (pinsOut.dataOe |-> pinsOut.outGate_n)
    else $error("host drives data while device gate is low");
  a_release_then_drive: assert property
    ($rose(pinsOut.dataOe) |-> $past(pinsOut.outGate_n, 1) && $past(pinsOut.outGate_n, 2))
    else $error("data driven too soon after gate rise");
  a_verify_mode: assert property
    (stateQ == PG_VERIFY |-> pinsOut.vppHigh && !pinsOut.csStrobe && !pinsOut.outGate_n)
    else $error("verify pins not in verify mode");
  a_read_supply_low: assert property
    (stateQ == RD_ACC || stateQ == IDLE |-> !pinsOut.vppHigh)
    else $error("programming supply high during read or standby");
  a_read_answer_time: assert property
    ($rose(stateQ == RD_ACC) |-> ##(ACCESS_CYC + SYNC_LAT) rspValid)
    else $error("read answer not at expected cycle");

  c_read_done: cover property (rspValid && !pinsOut.vppHigh);
  c_prog_ok: cover property (rspValid && rspOut.match && $past(stateQ) == PG_VERIFY);
  c_prog_bad: cover property (rspValid && !rspOut.match);
  c_back_to_back: cover property (accept ##[1:40] accept);

endmodule // eprom_prog_host
`default_nettype wire

// ===== tb/eprom_model.sv
// behavioural 2k x 8 uv eprom sitting on the host's pins
// assumes pins_t from eprom_ctl_pkg; timing kept in ns, not clocks
`timescale 1ns/100ps
`default_nettype none
module eprom_model
  import eprom_ctl_pkg::*;
(
  input  wire pins_t      pinsIn,
  output var  logic [7:0] dataIn,
  output var  int         pulseCount,
  output var  realtime    pulseWidth
);
  logic [7:0] mem [0:2047];
  logic [7:0] lastVal;
  realtime    selT;
  realtime    gateT;
  realtime    riseT;
  wire        outOn  = !pinsIn.csStrobe && !pinsIn.outGate_n;
  wire        progOk = pinsIn.vppHigh && pinsIn.outGate_n;

  initial
  begin
    for (int i = 0; i < 2048; i++) mem[i] = 8'hFF;
    lastVal = 8'h00;
    selT = 0;
    gateT = 0;
    riseT = 0;
    pulseCount = 0;
    pulseWidth = 0;
  end

  always @(pinsIn.addr or negedge pinsIn.csStrobe) selT = $realtime;
  always @(negedge pinsIn.outGate_n) gateT = $realtime;
  always @(posedge pinsIn.csStrobe) riseT = progOk ? $realtime : 0.0;

  always @(negedge pinsIn.csStrobe)
  begin
    if (progOk && riseT > 0)
    begin
      mem[pinsIn.addr] &= pinsIn.dataOut;
      pulseCount++;
      pulseWidth = $realtime - riseT;
      riseT = 0.0;
    end
  end

  // released lines show the inverse of the last driven word, never stale data
  always #10
  begin
    if (pinsIn.dataOe)
    begin
      dataIn  = pinsIn.dataOut;
      lastVal = pinsIn.dataOut;
    end
    else if (outOn && $realtime >= selT + 450 && $realtime >= gateT + 120)
    begin
      dataIn  = mem[pinsIn.addr];
      lastVal = mem[pinsIn.addr];
    end
    else
    begin
      dataIn = ~lastVal;
    end
  end
endmodule // eprom_model
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the eprom programming host
// assumes eprom_model on the pins and a shortened program pulse
`timescale 1ns/100ps
`default_nettype none
module tb;
  import eprom_ctl_pkg::*;
  localparam int PULSE = 20;
  logic       ref_clk  = 1'b0;
  logic       rst_n    = 1'b0;
  logic       cmdValid = 1'b0;
  cmd_t       cmdIn    = '0;
  logic       cmdReady;
  logic       rspValid;
  rsp_t       rspOut;
  rsp_t       rsp;
  pins_t      pinsOut;
  logic [7:0] dataIn;
  int         pulseCount;
  realtime    pulseWidth;
  int         bad_count  = 0;
  int         num_checks = 0;

  always #50 ref_clk = ~ref_clk;

  eprom_prog_host #(.PULSE_CYC(PULSE), .PULSE_MAX_CYC(22), .SETUP_CYC(2)) i_dut
  (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .cmdValid (cmdValid),
    .cmdIn    (cmdIn),
    .cmdReady (cmdReady),
    .rspValid (rspValid),
    .rspOut   (rspOut),
    .pinsOut  (pinsOut),
    .dataIn   (dataIn)
  );

  eprom_model i_mem
  (
    .pinsIn     (pinsOut),
    .dataIn     (dataIn),
    .pulseCount (pulseCount),
    .pulseWidth (pulseWidth)
  );

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task tally_and_finish;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one command, held until taken, then wait for the answer
  task automatic run_cmd(input op_t op, input logic [10:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cmdValid = 1'b1;
    cmdIn = '{op: op, addr: a, data: d};
    while (cmdReady !== 1'b1 && n < 50)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    @(posedge ref_clk);
    #1;
    cmdValid = 1'b0;
    n = 0;
    while (rspValid !== 1'b1 && n < 200)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check(16'(n < 200), 16'h0001);
    rsp = rspOut;
  endtask

  task automatic read_expect(input logic [10:0] a, input logic [7:0] d, input logic m);
    run_cmd(OP_READ, a, 8'h00);
    check({rsp.data, 7'h00, rsp.match}, {d, 7'h00, m});
  endtask

  task automatic prog_expect(input logic [10:0] a, input logic [7:0] d, input logic [7:0] rb,
                             input logic m, input int cnt);
    run_cmd(OP_PROGRAM, a, d);
    check({rsp.data, 7'h00, rsp.match}, {rb, 7'h00, m});
    check(16'(pulseCount), 16'(cnt));
    check(16'(int'(pulseWidth)), 16'(PULSE * CLK_PERIOD_NS));
    @(posedge ref_clk);
    #1;
    check({13'h0000, pinsOut.csStrobe, pinsOut.vppHigh, pinsOut.dataOe}, 16'h0004);
  endtask

  // host must never drive the data pins while the device may drive them
  always @(posedge ref_clk)
  begin
    if (rst_n && pinsOut.dataOe === 1'b1 && pinsOut.outGate_n !== 1'b1)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end
  end

  initial
  begin
    #1_000_000;
    bad_count++;
    tally_and_finish();
  end

  initial
  begin
    repeat (20) @(posedge ref_clk);
    #1;
    check({12'h000, pinsOut.csStrobe, pinsOut.outGate_n, pinsOut.vppHigh, pinsOut.dataOe},
          16'h000C);
    rst_n = 1'b1;
    @(posedge ref_clk);
    #1;
    check(16'(cmdReady), 16'h0001);
    $display("test reset done");
    read_expect(11'h7FF, 8'hFF, 1'b1);
    $display("test read_erased done");
    prog_expect(11'h7FF, 8'h5A, 8'h5A, 1'b1, 1);
    $display("test program done");
    prog_expect(11'h7FF, 8'hFF, 8'h5A, 1'b0, 2);
    $display("test ones_keep done");
    prog_expect(11'h000, 8'hC3, 8'hC3, 1'b1, 3);
    read_expect(11'h7FF, 8'h5A, 1'b1);
    read_expect(11'h000, 8'hC3, 1'b1);
    read_expect(11'h001, 8'hFF, 1'b1);
    $display("test random_order done");
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
